// ---- pmwc_defines.svh ----
// Purpose: constants for the power mode and wake control block
// Assumes: 100 MHz sys_clk_i, AXI4-Lite register access
// Notes:   offsets are byte addresses of aligned words
//
// What this block does
// R1: line three pin from port B, bits 7:6
// R2: line two pin from port B, bits 5:4
// R3: port B line 4 never wakes halt
// R4: line one pin from port A, bits 3:2
// R5: line zero pin from port A, bits 1:0
// R6: pin select register read/write, reset 0Ch
// R7: reset enters run at master clock
// R8: slow select divides clock by 32
// R9: wait during slow gives slow-wait
// R10: wait stops CPU, peripherals keep running
// R11: wait entry clears interrupt mask
// R12: wait ends on interrupt or reset, vector branch
// R13: service pushes flags, mask set till pop
// R14: plain halt only without active-halt or auto-wake
// R15: active-halt enable from timer enable bits
// R16: halt exit waits 256 or 4096 cycles
// R17: halt entry forces interrupt mask to zero
// R18: halt stops oscillator and peripherals
// R19: watchdog-in-halt option gives watchdog reset
// R20: clock loop adds start-up delay after wake
// R21: pending unmasked external lines wake halt
// R22: line three code 11 selects no pin
`ifndef PMWC_DEFINES_SVH
`define PMWC_DEFINES_SVH
`define PMWC_OFS_PIN_SEL   12'h000
`define PMWC_OFS_CLK_CTRL  12'h004
`define PMWC_OFS_WAKE_CFG  12'h008
`define PMWC_OFS_STATUS    12'h00c
`define PMWC_PIN_SEL_RST   8'h0c
`define PMWC_L3_MSB        7
`define PMWC_L2_MSB        5
`define PMWC_L1_MSB        3
`define PMWC_L0_MSB        1
`define PMWC_SLOW_DIV      32
`define PMWC_STARTUP_SHORT 256
`define PMWC_STARTUP_LONG  4096
`define PMWC_LOOP_STARTUP  64
`endif

// ---- pmwc_pkg.sv ----
// Purpose: types for the power mode and wake control block
// Assumes: nothing beyond the defines header
// Notes:   mode encodings run from zero in declaration order
package pmwc_pkg;
  typedef enum logic [2:0] {PMWC_RUN, PMWC_WAIT, PMWC_HALT, PMWC_STARTUP, PMWC_LOOP} pmwc_mode_t;
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } pmwc_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pmwc_axi_rsp_t;
endpackage

// ---- pmwc_top.sv ----
// Purpose: power mode sequencing, clock gating and external wake routing
// Assumes: core pulses the wait/halt requests; pins synchronous to sys_clk_i
// Notes:   clock enables are outputs; actual gating cells sit outside
`timescale 1ns/1ps
`include "pmwc_defines.svh"
module pmwc_top #(
  parameter int STARTUP_LONG = `PMWC_STARTUP_LONG,
  parameter int SLOW_DIV     = `PMWC_SLOW_DIV
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  input  wire pmwc_pkg::pmwc_axi_req_t axi_req_i,
  output pmwc_pkg::pmwc_axi_rsp_t      axi_rsp_o,
  input  wire logic [6:0]             port_b_i,
  input  wire logic [7:0]             port_a_i,
  input  wire logic                   wfi_instr_i,
  input  wire logic                   halt_instr_i,
  input  wire logic                   irq_pending_i,
  input  wire logic                   halt_wake_irq_i,
  input  wire logic                   vector_taken_i,
  input  wire logic                   ccr_popped_i,
  input  wire logic                   watchdog_on_i,
  input  wire logic                   timebase_one_irq_enable_i,
  input  wire logic                   reload_overflow_irq_enable_i,
  input  wire logic [1:0]             reload_clock_select_i,
  input  wire logic                   auto_wake_enable_i,
  output logic [3:0]                  ext_irq_line_o,
  output logic                        irq_mask_o,
  output logic                        ccr_push_o,
  output logic                        cpu_clk_en_o,
  output logic                        periph_clk_en_o,
  output logic                        osc_on_o,
  output logic                        watchdog_reset_o,
  output logic                        active_halt_req_o,
  output logic                        fetch_vector_o
);
  import pmwc_pkg::*;

  initial begin
    if (STARTUP_LONG < 2 || STARTUP_LONG > 65535 || SLOW_DIV < 2 || SLOW_DIV > 255) begin
      $error("pmwc_top: unsupported parameter value");
    end
  end

  localparam logic [15:0] START_SHORT_C = 16'(`PMWC_STARTUP_SHORT);
  localparam logic [15:0] START_LONG_C  = 16'(STARTUP_LONG);
  localparam logic [15:0] LOOP_C        = 16'(`PMWC_LOOP_STARTUP);
  localparam logic [7:0]  SLOW_LAST_C   = 8'(SLOW_DIV - 1);

  // registers
  logic [7:0]  pin_sel;
  logic        slow_sel;
  logic        long_start;
  logic        loop_en;
  logic        wdg_halt_opt;
  pmwc_mode_t  mode;
  logic [15:0] cnt;
  logic [7:0]  slow_cnt;
  logic        in_service;
  logic        mask;
  logic [3:0]  line_q;

  // pin routing
  wire [1:0] line_three_pin_field = pin_sel[`PMWC_L3_MSB -: 2];
  wire [1:0] line_two_pin_field   = pin_sel[`PMWC_L2_MSB -: 2];
  wire [1:0] line_one_pin_field   = pin_sel[`PMWC_L1_MSB -: 2];
  wire [1:0] line_zero_pin_field  = pin_sel[`PMWC_L0_MSB -: 2];
  wire ext_irq_line_three = (line_three_pin_field == 2'h3) ? 1'b0 : port_b_i[line_three_pin_field]; // R1 R22
  wire ext_irq_line_two   = port_b_i[3'(line_two_pin_field) + 3'h3];                                 // R2
  wire ext_irq_line_one   = port_a_i[3'(line_one_pin_field) + 3'h4];                                 // R4
  wire ext_irq_line_zero  = port_a_i[3'(line_zero_pin_field)];                                       // R5
  wire [3:0] next_line    = {ext_irq_line_three, ext_irq_line_two, ext_irq_line_one, ext_irq_line_zero};
  // port b line 4 has no wake path with the oscillator off
  wire line_two_halt_ok   = (line_two_pin_field != 2'h1); // R3
  wire [3:0] wake_lines   = line_q & {1'b1, line_two_halt_ok, 2'b11};
  wire ext_wake           = (|wake_lines) && !mask; // R21

  // halt decision
  wire active_halt_en = timebase_one_irq_enable_i ||
                        (reload_overflow_irq_enable_i && reload_clock_select_i == 2'h1); // R15
  wire plain_halt     = !active_halt_en && !auto_wake_enable_i; // R14
  wire halt_to_wdg    = halt_instr_i && watchdog_on_i && wdg_halt_opt && !active_halt_en; // R19

  // bus decode
  wire wr_go     = axi_req_i.awvalid && axi_req_i.wvalid && !axi_rsp_o.bvalid;
  wire rd_go     = axi_req_i.arvalid && !axi_rsp_o.rvalid;
  wire wr_pin    = wr_go && axi_req_i.awaddr == `PMWC_OFS_PIN_SEL && axi_req_i.wstrb[0];
  wire wr_clk    = wr_go && axi_req_i.awaddr == `PMWC_OFS_CLK_CTRL && axi_req_i.wstrb[0];
  wire wr_cfg    = wr_go && axi_req_i.awaddr == `PMWC_OFS_WAKE_CFG && axi_req_i.wstrb[0];
  wire wr_hit    = axi_req_i.awaddr == `PMWC_OFS_PIN_SEL || axi_req_i.awaddr == `PMWC_OFS_CLK_CTRL ||
                   axi_req_i.awaddr == `PMWC_OFS_WAKE_CFG || axi_req_i.awaddr == `PMWC_OFS_STATUS;
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    if (axi_req_i.araddr == `PMWC_OFS_PIN_SEL) begin
      rd_word = {24'h0, pin_sel}; // R6
    end else if (axi_req_i.araddr == `PMWC_OFS_CLK_CTRL) begin
      rd_word = {31'h0, slow_sel};
    end else if (axi_req_i.araddr == `PMWC_OFS_WAKE_CFG) begin
      rd_word = {29'h0, wdg_halt_opt, loop_en, long_start};
    end else if (axi_req_i.araddr == `PMWC_OFS_STATUS) begin
      rd_word = {24'h0, line_q, mask, 3'(mode)};
    end else begin
      rd_word = 32'h0;
      rd_hit  = 1'b0;
    end
  end
  assign axi_rsp_o.awready = wr_go;
  assign axi_rsp_o.wready  = wr_go;
  assign axi_rsp_o.arready = rd_go;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      axi_rsp_o.bvalid <= 1'b0;
      axi_rsp_o.bresp  <= 2'h0;
      axi_rsp_o.rvalid <= 1'b0;
      axi_rsp_o.rdata  <= 32'h0;
      axi_rsp_o.rresp  <= 2'h0;
    end else begin
      if (wr_go) begin
        axi_rsp_o.bvalid <= 1'b1;
        axi_rsp_o.bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (axi_req_i.bready) begin
        axi_rsp_o.bvalid <= 1'b0;
      end
      if (rd_go) begin
        axi_rsp_o.rvalid <= 1'b1;
        axi_rsp_o.rdata  <= rd_word;
        axi_rsp_o.rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (axi_req_i.rready) begin
        axi_rsp_o.rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sel      <= `PMWC_PIN_SEL_RST; // R6
      slow_sel     <= 1'b0;
      long_start   <= 1'b0;
      loop_en      <= 1'b0;
      wdg_halt_opt <= 1'b0;
      line_q       <= 4'h0;
    end else begin
      line_q <= next_line;
      if (wr_pin) begin
        pin_sel <= axi_req_i.wdata[7:0]; // R6
      end
      if (wr_clk) begin
        slow_sel <= axi_req_i.wdata[0];
      end
      if (wr_cfg) begin
        long_start   <= axi_req_i.wdata[0];
        loop_en      <= axi_req_i.wdata[1];
        wdg_halt_opt <= axi_req_i.wdata[2];
      end
    end
  end

  // mode sequencer
  wire wake_any = irq_pending_i || (|line_q && !mask);
  wire cnt_done = (cnt == 16'h1);
  pmwc_mode_t next_mode;
  logic [15:0] next_cnt;
  always_comb begin
    next_mode = mode;
    next_cnt  = (cnt != 16'h0) ? cnt - 16'h1 : 16'h0;
    case (mode)
      PMWC_RUN: begin
        if (halt_instr_i && plain_halt && !halt_to_wdg) begin
          next_mode = PMWC_HALT; // R14
        end else if (wfi_instr_i) begin
          next_mode = PMWC_WAIT; // R10 R9
        end
      end
      PMWC_WAIT: begin
        if (wake_any) begin
          next_mode = PMWC_RUN; // R12
        end
      end
      PMWC_HALT: begin
        if (ext_wake || halt_wake_irq_i) begin
          next_mode = PMWC_STARTUP; // R16
          next_cnt  = long_start ? START_LONG_C : START_SHORT_C;
        end
      end
      PMWC_STARTUP: begin
        if (cnt_done) begin
          next_mode = loop_en ? PMWC_LOOP : PMWC_RUN; // R20
          next_cnt  = LOOP_C;
        end
      end
      PMWC_LOOP: begin
        if (cnt_done) begin
          next_mode = PMWC_RUN;
        end
      end
      default: next_mode = PMWC_RUN;
    endcase
  end

  // slow divider: one cpu enable per divide period
  wire slow_tick = (slow_cnt == 8'h0);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode     <= PMWC_RUN; // R7
      cnt      <= 16'h0;
      slow_cnt <= 8'h0;
    end else begin
      mode     <= next_mode;
      cnt      <= next_cnt;
      slow_cnt <= (slow_tick || !slow_sel) ? SLOW_LAST_C : slow_cnt - 8'h1; // R8
    end
  end

  // interrupt mask: entry into wait/halt clears it, service sets it, pop clears
  wire enter_low = (mode == PMWC_RUN) && (next_mode == PMWC_WAIT || next_mode == PMWC_HALT);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask       <= 1'b1;
      in_service <= 1'b0;
    end else begin
      if (vector_taken_i) begin
        mask       <= 1'b1; // R13
        in_service <= 1'b1;
      end else if (enter_low) begin
        mask <= 1'b0; // R11 R17
      end else if (ccr_popped_i && in_service) begin
        mask       <= 1'b0; // R13
        in_service <= 1'b0;
      end
    end
  end

  // gating outputs; wait keeps peripherals, halt stops all
  wire clk_tick = slow_sel ? slow_tick : 1'b1; // R8 R9
  assign cpu_clk_en_o      = (mode == PMWC_RUN) && clk_tick; // R10
  assign periph_clk_en_o   = (mode == PMWC_RUN || mode == PMWC_WAIT) && clk_tick; // R18
  assign osc_on_o          = (mode != PMWC_HALT); // R18 R16
  assign watchdog_reset_o  = halt_to_wdg; // R19
  assign active_halt_req_o = halt_instr_i && !plain_halt && !halt_to_wdg;
  assign fetch_vector_o    = (mode != PMWC_RUN) && (next_mode == PMWC_RUN); // R12
  assign ccr_push_o        = vector_taken_i; // R13
  assign irq_mask_o        = mask;
  assign ext_irq_line_o    = line_q;

  // cycles spent in the present mode; long repetitions stall the checkers, so count instead
  logic [15:0] phase_cycles;
  logic [15:0] su_want;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_cycles <= 16'h0;
    end else begin
      phase_cycles <= (next_mode == mode) ? phase_cycles + 16'h1 : 16'h0;
    end
  end
  // startup length latched at wake so a bus write mid-startup cannot blur the check
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      su_want <= START_SHORT_C;
    end else if (mode == PMWC_HALT && next_mode == PMWC_STARTUP) begin
      su_want <= long_start ? START_LONG_C : START_SHORT_C;
    end
  end

  a_halt_mask_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R17
    (mode == PMWC_RUN && halt_instr_i && plain_halt && !halt_to_wdg && !vector_taken_i) |=> !mask)
    else $error("mask not cleared on halt");
  a_wait_mask_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
    (mode == PMWC_RUN && wfi_instr_i && !halt_instr_i && !vector_taken_i) |=> (mode == PMWC_WAIT && !mask))
    else $error("wait entry wrong");
  a_halt_osc_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R18
    (mode == PMWC_HALT) |-> (!osc_on_o && !cpu_clk_en_o && !periph_clk_en_o))
    else $error("clocks run in halt");
  a_wait_periph: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R10
    (mode == PMWC_WAIT && !slow_sel) |-> (periph_clk_en_o && !cpu_clk_en_o))
    else $error("wait gating wrong");
  a_startup_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R16
    (mode == PMWC_STARTUP && next_mode != PMWC_STARTUP) |-> (phase_cycles == su_want - 16'h1))
    else $error("startup length wrong");
  a_loop_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R20
    (mode == PMWC_LOOP && next_mode != PMWC_LOOP) |-> (phase_cycles == LOOP_C - 16'h1))
    else $error("loop delay length wrong");
  a_startup_clocks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R16
    (mode == PMWC_STARTUP || mode == PMWC_LOOP) |-> (osc_on_o && !cpu_clk_en_o && !periph_clk_en_o))
    else $error("clocks given during startup");

  // halt entry and exit
  a_halt_refused: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R14
    (mode == PMWC_RUN && halt_instr_i && !plain_halt) |=> mode != PMWC_HALT)
    else $error("plain halt entered wrongly");
  a_active_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R15
    (mode == PMWC_RUN && halt_instr_i && timebase_one_irq_enable_i && !wfi_instr_i) |=> mode == PMWC_RUN)
    else $error("halt taken with active-halt on");
  a_wdg_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R19
    (halt_instr_i && watchdog_on_i && wdg_halt_opt && !active_halt_en) |-> watchdog_reset_o)
    else $error("watchdog reset missing");
  a_halt_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R21
    (mode == PMWC_HALT && !ext_wake && !halt_wake_irq_i) |=> mode == PMWC_HALT)
    else $error("halt left without wake");
  a_halt_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R21
    (mode == PMWC_HALT && (|wake_lines) && !mask) |=> mode == PMWC_STARTUP)
    else $error("line did not wake halt");

  // wait entry and exit
  a_wait_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
    (mode == PMWC_WAIT && !wake_any) |=> mode == PMWC_WAIT)
    else $error("wait left without wake");
  a_wait_exit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
    (mode == PMWC_WAIT && irq_pending_i) |-> fetch_vector_o ##1 (mode == PMWC_RUN))
    else $error("wait exit wrong");
  a_slow_wait: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R9
    (mode == PMWC_WAIT && slow_sel && !wr_clk && periph_clk_en_o) |=> !periph_clk_en_o)
    else $error("slow-wait rate wrong");
  a_fast_run: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R7
    (mode == PMWC_RUN && !slow_sel) |-> (cpu_clk_en_o && periph_clk_en_o))
    else $error("run clocks missing");

  // service mask
  a_mask_service: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
    vector_taken_i |=> mask)
    else $error("mask not set in service");
  a_push_vector: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
    vector_taken_i |-> ccr_push_o)
    else $error("flags not pushed");
  a_mask_pop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
    (ccr_popped_i && in_service && !vector_taken_i && !enter_low) |=> !mask)
    else $error("mask not cleared on pop");

  // pin routing and register
  a_line_zero_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R5
    (line_zero_pin_field == 2'h2) |=> line_q[0] == $past(port_a_i[2]))
    else $error("line zero route wrong");
  a_line_one_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R4
    (line_one_pin_field == 2'h3) |=> line_q[1] == $past(port_a_i[7]))
    else $error("line one route wrong");
  a_line_two_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
    (line_two_pin_field == 2'h3) |=> line_q[2] == $past(port_b_i[6]))
    else $error("line two route wrong");
  a_line_three_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
    (line_three_pin_field == 2'h0) |=> line_q[3] == $past(port_b_i[0]))
    else $error("line three route wrong");
  a_pin_sel_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R6
    wr_pin |=> pin_sel == $past(axi_req_i.wdata[7:0]))
    else $error("pin select write lost");
  a_write_resp: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_go |=> axi_rsp_o.bvalid)
    else $error("write response missing");
  a_read_resp: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_go |=> axi_rsp_o.rvalid)
    else $error("read response missing");
  a_line_three_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R22
    (line_three_pin_field == 2'h3) |=> !line_q[3])
    else $error("line three code 11 active");
  a_pb4_no_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R3
    (mode == PMWC_HALT && line_two_pin_field == 2'h1 && line_q == 4'h4 && !halt_wake_irq_i) |=> mode == PMWC_HALT)
    else $error("pb4 woke halt");
  a_wdg_no_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R19
    watchdog_reset_o |=> mode != PMWC_HALT)
    else $error("halt entered on watchdog");
  a_slow_rate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
    (slow_sel && $past(slow_sel) && !wr_clk && cpu_clk_en_o) |=> !cpu_clk_en_o)
    else $error("slow rate wrong");
  c_wait_wake: cover property (@(posedge sys_clk_i) mode == PMWC_WAIT ##1 mode == PMWC_RUN);
  c_halt_wake: cover property (@(posedge sys_clk_i) mode == PMWC_HALT ##1 mode == PMWC_STARTUP);
  c_loop: cover property (@(posedge sys_clk_i) mode == PMWC_LOOP);
  c_slow_wait: cover property (@(posedge sys_clk_i) mode == PMWC_WAIT && slow_sel && periph_clk_en_o);
  c_wdg_reset: cover property (@(posedge sys_clk_i) watchdog_reset_o);
endmodule

// ---- pmwc_core_model.sv ----
// Purpose: core stand-in that answers vector fetches and returns from service
// Assumes: fetch_vector_i is a one-cycle pulse from the block
// Notes:   service routine length fixed at five cycles, enough to see the mask held
`timescale 1ns/1ps
module pmwc_core_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic fetch_vector_i,
  output logic      vector_taken_o,
  output logic      ccr_popped_o
);
  logic [2:0] svc_cnt;
  logic       in_svc;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vector_taken_o <= 1'b0;
      ccr_popped_o   <= 1'b0;
      svc_cnt        <= 3'h0;
      in_svc         <= 1'b0;
    end else begin
      vector_taken_o <= fetch_vector_i;
      ccr_popped_o   <= in_svc && (svc_cnt == 3'h4);
      if (vector_taken_o) begin
        in_svc  <= 1'b1;
        svc_cnt <= 3'h0;
      end else if (in_svc) begin
        svc_cnt <= svc_cnt + 3'h1;
        if (svc_cnt == 3'h4) in_svc <= 1'b0;
      end
    end
  end
endmodule

// ---- power_mode_wake_control_bench.sv ----
// Purpose: self-checking bench for the power mode and wake control block
// Assumes: short startup count 256, long count shrunk to 300
// Notes:   pulse outputs caught by sticky flags so a one-cycle pulse is not missed
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module power_mode_wake_control_bench;
  import pmwc_pkg::*;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
  pmwc_axi_req_t req = '0;
  pmwc_axi_rsp_t rsp;
  logic [6:0] port_b = 7'h00;
  logic [7:0] port_a = 8'h00;
  logic wait_for_interrupt_instr = 1'b0, halt = 1'b0, pend = 1'b0, hwake = 1'b0, wdog = 1'b0, tb1 = 1'b0, ovf = 1'b0, awu = 1'b0;
  logic [1:0] cks = 2'h0;
  logic vtaken, popped, wd_seen, ah_seen;
  logic [3:0] lines;
  logic mask, push, cpu_en, per_en, osc, wd_rst, ah_req, fetch;
  int miscompares = 0, compares = 0, cyc = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  pmwc_top #(.STARTUP_LONG(300), .SLOW_DIV(32)) i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .axi_req_i(req), .axi_rsp_o(rsp), .port_b_i(port_b), .port_a_i(port_a), .wfi_instr_i(wait_for_interrupt_instr),
    .halt_instr_i(halt), .irq_pending_i(pend), .halt_wake_irq_i(hwake), .vector_taken_i(vtaken),
    .ccr_popped_i(popped), .watchdog_on_i(wdog), .timebase_one_irq_enable_i(tb1),
    .reload_overflow_irq_enable_i(ovf), .reload_clock_select_i(cks), .auto_wake_enable_i(awu),
    .ext_irq_line_o(lines), .irq_mask_o(mask), .ccr_push_o(push), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(per_en), .osc_on_o(osc), .watchdog_reset_o(wd_rst),
    .active_halt_req_o(ah_req), .fetch_vector_o(fetch));
  pmwc_core_model i_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fetch_vector_i(fetch),
    .vector_taken_o(vtaken), .ccr_popped_o(popped));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  always @(posedge sys_clk_i) begin
    wd_seen <= (wd_seen === 1'b1) || (wd_rst === 1'b1);
    ah_seen <= (ah_seen === 1'b1) || (ah_req === 1'b1);
  end
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= d; req.wstrb <= 4'hf;
    do @(posedge sys_clk_i); while (!(rsp.awready === 1'b1 && rsp.wready === 1'b1) && ++n < 50);
    req.awvalid <= 1'b0; req.wvalid <= 1'b0; req.bready <= 1'b1;
    do @(posedge sys_clk_i); while (rsp.bvalid !== 1'b1 && ++n < 100);
    req.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    req.arvalid <= 1'b1; req.araddr <= a;
    do @(posedge sys_clk_i); while (rsp.arready !== 1'b1 && ++n < 50);
    req.arvalid <= 1'b0; req.rready <= 1'b1;
    do @(posedge sys_clk_i); while (rsp.rvalid !== 1'b1 && ++n < 100);
    rd = rsp.rdata; rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic pulse(input logic is_halt);
    if (is_halt) halt <= 1'b1;
    else wait_for_interrupt_instr <= 1'b1;
    @(posedge sys_clk_i);
    halt <= 1'b0;
    wait_for_interrupt_instr <= 1'b0;
    @(posedge sys_clk_i); #1;
  endtask
  task automatic t_regs();
    `CHK({osc, cpu_en, per_en}, 3'b111)
    rdr(12'h000); `CHK(rd, 32'h0000000c)
    wr(12'h000, 32'h000000a5); rdr(12'h000); `CHK(rd, 32'h000000a5)
    rdr(12'h010); `CHK(rr, 2'h2)
    $display("regs done");
  endtask
  task automatic t_route();
    for (int c = 0; c < 4; c++) begin
      wr(12'h000, {24'h0, c[1:0], c[1:0], c[1:0], c[1:0]});
      port_a <= 8'h01 << c | 8'h10 << c;
      port_b <= (c == 3) ? 7'h7f : (7'h01 << c | 7'h08 << c);
      repeat (3) @(posedge sys_clk_i);
      `CHK(lines, {c != 3, 3'b111})
      port_a <= 8'h00; port_b <= 7'h00; @(posedge sys_clk_i);
    end
    $display("route done");
  endtask
  task automatic t_wait();
    int n;
    pulse(1'b0); `CHK({cpu_en, per_en, mask}, 3'b010)
    pend <= 1'b1; n = 0;
    do @(posedge sys_clk_i); while (fetch !== 1'b1 && ++n < 50);
    pend <= 1'b0; repeat (2) @(posedge sys_clk_i); #1;
    `CHK({cpu_en, mask}, 2'b11)
    repeat (8) @(posedge sys_clk_i); `CHK(mask, 1'b0)
    $display("wait done");
  endtask
  task automatic t_halt();
    int n;
    wr(12'h000, 32'h00000010); pulse(1'b1);
    `CHK({osc, per_en, cpu_en, mask}, 4'b0000)
    port_b <= 7'h10; repeat (20) @(posedge sys_clk_i); `CHK(osc, 1'b0)
    port_b <= 7'h00; port_a <= 8'h01; n = 0;
    do @(posedge sys_clk_i); while (fetch !== 1'b1 && ++n < 400);
    port_a <= 8'h00;
    `CHK(n >= 256 && n <= 262, 1'b1)
    repeat (10) @(posedge sys_clk_i);
    wr(12'h008, 32'h00000002); pulse(1'b1); port_a <= 8'h01; n = 0;
    do @(posedge sys_clk_i); while (fetch !== 1'b1 && ++n < 400);
    port_a <= 8'h00;
    `CHK(n >= 320 && n <= 326, 1'b1)
    wr(12'h008, 32'h00000000); repeat (10) @(posedge sys_clk_i);
    $display("halt done");
  endtask
  task automatic t_modes();
    int n;
    tb1 <= 1'b1; pulse(1'b1); tb1 <= 1'b0;
    `CHK({ah_seen, cpu_en, osc}, 3'b111)
    wr(12'h008, 32'h00000004); wdog <= 1'b1; pulse(1'b1); wdog <= 1'b0;
    `CHK({wd_seen, osc}, 2'b11)
    wr(12'h008, 32'h00000000); wr(12'h004, 32'h00000001); n = 0;
    repeat (64) begin @(posedge sys_clk_i); n += (cpu_en === 1'b1); end
    `CHK(n, 2)
    pulse(1'b0); n = 0;
    repeat (64) begin @(posedge sys_clk_i); n += (per_en === 1'b1); end
    `CHK({n == 2, cpu_en}, 2'b10)
    $display("modes done");
  endtask
  initial begin
    wd_seen = 1'b0; ah_seen = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1; @(posedge sys_clk_i); #1;
    t_regs(); t_route(); t_wait(); t_halt(); t_modes();
    results();
  end
endmodule
